/* File: rtl/adc_dev.sv */
// Converter end: daisy-chain readout of a 16-bit sampled result.
// Assumes the host drives conv_start and link_clk, and chains serial pins.
`timescale 1ns/1ps
module adc_dev
    import adc_pkg::*;
(
    input  wire logic             SYS_CLK,
    input  wire logic             RESETN,
    adc_link_if.dev               LNK,
    input  wire logic [RES_W-1:0] SAMPLE_IN,
    output logic                  CONV_DONE,
    output logic                  POWERED,
    output logic                  DAISY_MODE,
    output logic                  BUSY_SEL
);

    // Pin synchronisers into the system domain
    logic                  conv_s1_r;
    logic                  conv_s2_r;
    logic                  conv_d_r;
    logic                  din_s1_r;
    logic                  din_s2_r;
    logic                  din_d_r;
    logic                  sck_s1_r;
    logic                  sck_s2_r;
    logic                  sck_d_r;

    // Conversion state
    logic                  converting_r;
    logic [CONV_CNT_W-1:0] conv_cnt_r;
    logic [RES_W-1:0]      sample_r;
    logic [RES_W-1:0]      result_r;
    logic                  daisy_r;
    logic                  busy_sel_r;
    logic                  done_r;
    logic                  hold_low_r;

    // Link-side shift state
    logic                  link_clr_n;
    logic [EDGE_W-1:0]     edge_cnt_r;
    logic [RES_W-1:0]      in_sr_r;

    // Output view
    logic                  conv_rise;
    logic [EDGE_W-1:0]     data_idx;
    logic                  dout;
    logic                  dout_oe;

    // Last count of the conversion timer, shared by the timer and the result load
    function automatic logic conv_last(input logic [CONV_CNT_W-1:0] cnt);
        return cnt == CONV_CNT_W'(CONV_CYCLES - 1);
    endfunction : conv_last

    // Two-stage synchronisers, then one delay stage for edge and level history
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            conv_s1_r <= 1'b0;
            conv_s2_r <= 1'b0;
            conv_d_r  <= 1'b0;
            din_s1_r  <= 1'b0;
            din_s2_r  <= 1'b0;
            din_d_r   <= 1'b0;
            sck_s1_r  <= 1'b0;
            sck_s2_r  <= 1'b0;
            sck_d_r   <= 1'b0;
        end else begin
            conv_s1_r <= LNK.conv_start;
            conv_s2_r <= conv_s1_r;
            conv_d_r  <= conv_s2_r;
            din_s1_r  <= LNK.chain_in;
            din_s2_r  <= din_s1_r;
            din_d_r   <= din_s2_r;
            sck_s1_r  <= LNK.link_clk;
            sck_s2_r  <= sck_s1_r;
            sck_d_r   <= sck_s2_r;
        end
    end

    // Start edge seen in the system domain
    assign conv_rise = conv_s2_r & ~conv_d_r;

    // Mode and busy choice caught from levels just before the start edge
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            daisy_r    <= 1'b0;
            busy_sel_r <= 1'b0;
        end else if (conv_rise && !converting_r) begin
            daisy_r    <= ~din_d_r;
            busy_sel_r <= sck_d_r;
        end
    end

    // Sample capture at the start edge
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sample_r <= '0;
        end else if (conv_rise && !converting_r) begin
            sample_r <= SAMPLE_IN;
        end
    end

    // Internally timed conversion, blind to the serial clock
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            converting_r <= 1'b0;
            conv_cnt_r   <= '0;
        end else if (!converting_r) begin
            if (conv_rise) begin
                converting_r <= 1'b1;
                conv_cnt_r   <= '0;
            end
        end else if (conv_last(conv_cnt_r)) begin
            converting_r <= 1'b0;
        end else begin
            conv_cnt_r   <= conv_cnt_r + 1'b1;
        end
    end

    // Result load at conversion end; held through acquisition
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            result_r <= '0;
            done_r   <= 1'b0;
        end else if (converting_r && conv_last(conv_cnt_r)) begin
            result_r <= sample_r;
            done_r   <= 1'b1;
        end else begin
            done_r   <= 1'b0;
        end
    end

    // Both start and serial input low forces the output low
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            hold_low_r <= 1'b0;
        end else begin
            hold_low_r <= ~conv_s2_r & ~din_s2_r;
        end
    end

    // Shift path is cleared while converting; link clock is idle then
    assign link_clr_n = RESETN & ~converting_r;

    // Falling-edge shift: capture serial input, advance output
    always_ff @(negedge LNK.link_clk or negedge link_clr_n) begin
        if (!link_clr_n) begin
            edge_cnt_r <= '0;
            in_sr_r    <= '0;
        end else begin
            if (edge_cnt_r != '0 || !busy_sel_r) begin
                in_sr_r <= {in_sr_r[RES_W-2:0], LNK.chain_in};
            end
            if (edge_cnt_r != EDGE_MAX) begin
                edge_cnt_r <= edge_cnt_r + 1'b1;
            end
        end
    end

    // Number of data shifts done, not counting the busy slot
    assign data_idx = (busy_sel_r && edge_cnt_r != '0) ? edge_cnt_r - 1'b1 : edge_cnt_r;

    // Serial output selection
    always_comb begin
        dout = 1'b0;
        if (hold_low_r) begin
            dout = 1'b0;
        end else if (converting_r) begin
            dout = 1'b0;                           // Low so the busy bit gives a rise
        end else if (busy_sel_r && edge_cnt_r == '0) begin
            dout = 1'b1;
        end else if (data_idx < EDGE_W'(RES_W)) begin
            dout = result_r[4'(RES_W - 1) - data_idx[3:0]];
        end else begin
            dout = in_sr_r[RES_W-1];
        end
    end

    // Drive only in chained mode or during the forced-low condition
    assign dout_oe = daisy_r | hold_low_r;

    assign LNK.chain_out    = dout;
    assign LNK.chain_out_oe = dout_oe;
    assign CONV_DONE        = done_r;
    assign POWERED          = converting_r;
    assign DAISY_MODE       = daisy_r;
    assign BUSY_SEL         = busy_sel_r;

endmodule : adc_dev

/* File: rtl/adc_pkg.sv */
// Shared constants for the daisy-chained converter readout, device and host ends.
// Assumes both ends run from a 40 MHz system clock.
package adc_pkg;

    // Result word width
    localparam int RES_W = 16;

    // System clock period and conversion time
    localparam int SYS_PERIOD_NS = 25;
    localparam int CONV_TIME_NS  = 1000;
    localparam int CONV_CYCLES   = (CONV_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int CONV_CNT_W    = $clog2(CONV_CYCLES + 1);

    // Falling-edge counter of the device shift path, saturating
    localparam int          EDGE_W   = 5;
    localparam logic [4:0]  EDGE_MAX = 5'h11;

    // Host timing: wait past conversion plus crossing margin, link clock half period
    localparam int HOST_WAIT_CYCLES = CONV_CYCLES + 8;
    localparam int HOST_WAIT_W      = $clog2(HOST_WAIT_CYCLES + 1);
    localparam int SCK_HALF_CYCLES  = 4;
    localparam int SCK_HALF_W       = 3;

    // Host chain size and bit counting
    localparam int DEVN_W = 4;
    localparam int BITS_W = 8;
    localparam int BIT_IN_WORD_W = 4;

    // Host sequencer states
    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_CONV = 3'h1,
        H_LOW  = 3'h2,
        H_HIGH = 3'h3,
        H_END  = 3'h4
    } adc_hst_e;

endpackage : adc_pkg

/* File: rtl/adc_link_if.sv */
// Link between the host and one converter in the chain.
// Assumes the bench joins further devices by wiring chain_out to the next chain_in.
`timescale 1ns/1ps
interface adc_link_if;
    logic conv_start;    // Shared conversion start line
    logic link_clk;      // Serial clock made by the host
    logic chain_in;      // Serial input of the device
    logic chain_out;     // Serial output of the device
    logic chain_out_oe;  // High while the device drives chain_out

    modport dev (
        input  conv_start,
        input  link_clk,
        input  chain_in,
        output chain_out,
        output chain_out_oe
    );

    modport host (
        output conv_start,
        output link_clk,
        output chain_in,
        input  chain_out,
        input  chain_out_oe
    );
endinterface : adc_link_if

/* File: rtl/adc_host.sv */
// Host end: starts a chained conversion and reads DEV_COUNT results back, last device first.
// Assumes one or more devices chained behind the link interface.
`timescale 1ns/1ps
module adc_host
    import adc_pkg::*;
(
    input  wire logic              SYS_CLK,
    input  wire logic              RESETN,
    adc_link_if.host               LNK,
    input  wire logic              START,
    input  wire logic              USE_BUSY,
    input  wire logic [DEVN_W-1:0] DEV_COUNT,
    output logic [RES_W-1:0]       RX_DATA,
    output logic                   RX_VALID,
    output logic                   DONE,
    output logic                   ACTIVE
);

    adc_hst_e               state_r;
    logic                   conv_r;
    logic                   sck_r;
    logic                   busy_r;
    logic [BITS_W-1:0]      total_r;
    logic [BITS_W-1:0]      falls_r;
    logic [HOST_WAIT_W-1:0] wait_r;
    logic [SCK_HALF_W-1:0]  half_r;
    logic [RES_W-1:0]       word_r;
    logic [BIT_IN_WORD_W-1:0] bit_r;
    logic [RES_W-1:0]       rx_data_r;
    logic                   rx_valid_r;
    logic                   done_r;
    logic                   dout_s1_r;
    logic                   dout_s2_r;
    logic                   half_end;
    logic                   take_bit;

    // Serial data synchroniser
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            dout_s1_r <= 1'b0;
            dout_s2_r <= 1'b0;
        end else begin
            dout_s1_r <= LNK.chain_out;
            dout_s2_r <= dout_s1_r;
        end
    end

    assign half_end = (half_r == SCK_HALF_W'(SCK_HALF_CYCLES - 1));
    // Busy slot sampled before the first fall is not data
    assign take_bit = !(busy_r && falls_r == '0);

    // Sequencer: start, wait out conversion, clock the chain, release start
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_r <= H_IDLE;
            conv_r  <= 1'b0;
            sck_r   <= 1'b0;
            busy_r  <= 1'b0;
            total_r <= '0;
            falls_r <= '0;
            wait_r  <= '0;
            half_r  <= '0;
        end else begin
            case (state_r)
                H_IDLE: begin
                    if (START) begin
                        busy_r  <= USE_BUSY;
                        sck_r   <= USE_BUSY;
                        total_r <= {DEV_COUNT, 4'h0} + BITS_W'(USE_BUSY);
                        falls_r <= '0;
                        wait_r  <= '0;
                        state_r <= H_CONV;
                    end
                end
                H_CONV: begin
                    conv_r <= 1'b1;
                    if (wait_r == HOST_WAIT_W'(HOST_WAIT_CYCLES - 1)) begin
                        half_r  <= '0;
                        state_r <= busy_r ? H_HIGH : H_LOW;
                    end else begin
                        wait_r <= wait_r + 1'b1;
                    end
                end
                H_LOW: begin
                    half_r <= half_r + 1'b1;
                    if (half_end) begin
                        half_r  <= '0;
                        sck_r   <= 1'b1;
                        state_r <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    half_r <= half_r + 1'b1;
                    if (half_end) begin
                        half_r  <= '0;
                        sck_r   <= 1'b0;  // Falling edge shifts the chain
                        falls_r <= falls_r + 1'b1;
                        state_r <= (falls_r + 1'b1 == total_r) ? H_END : H_LOW;
                    end
                end
                H_END: begin
                    conv_r  <= 1'b0;
                    state_r <= H_IDLE;
                end
                default: begin
                    state_r <= H_IDLE;
                end
            endcase
        end
    end

    // Bit assembly just before each falling edge, MSB first, last device first
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            word_r     <= '0;
            bit_r      <= '0;
            rx_data_r  <= '0;
            rx_valid_r <= 1'b0;
        end else begin
            rx_valid_r <= 1'b0;
            if (state_r == H_IDLE) begin
                bit_r <= '0;
            end else if (state_r == H_HIGH && half_end && take_bit) begin
                word_r <= {word_r[RES_W-2:0], dout_s2_r};
                bit_r  <= bit_r + 1'b1;
                if (bit_r == BIT_IN_WORD_W'(RES_W - 1)) begin
                    rx_data_r  <= {word_r[RES_W-2:0], dout_s2_r};
                    rx_valid_r <= 1'b1;
                end
            end
        end
    end

    // One-cycle completion pulse
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            done_r <= 1'b0;
        end else begin
            done_r <= (state_r == H_END);
        end
    end

    assign LNK.conv_start = conv_r;
    assign LNK.link_clk   = sck_r;
    assign LNK.chain_in   = 1'b0;  // First device input held low
    assign RX_DATA        = rx_data_r;
    assign RX_VALID       = rx_valid_r;
    assign DONE           = done_r;
    assign ACTIVE         = (state_r != H_IDLE);

endmodule : adc_host

/* File: verification/adc_link_sva.sv */
// Checker for the link between the host and the first converter.
// Assumes every signal is sampled on the system clock.
`timescale 1ns/1ps
module adc_link_sva
(
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic conv_start,
    input wire logic link_clk,
    input wire logic chain_in,
    input wire logic chain_out,
    input wire logic chain_out_oe
);
    logic [5:0] since_r;

    // Cycles since the start line rose, saturating
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN)
            since_r <= 6'h00;
        else if (!conv_start)
            since_r <= 6'h00;
        else if (since_r != 6'h3f)
            since_r <= since_r + 6'h01;
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    // Start edge with the link clock high asks for a busy bit
    sequence busy_start_s;
        $rose(conv_start) && link_clk;
    endsequence
    // Output stays low for eight cycles
    sequence quiet_s;
        (!chain_out) [*8];
    endsequence

    out_low_a: assert property ((!conv_start && !chain_in) [*4] |-> !chain_out)
        else $error("chain output not low while idle");
    conv_quiet_a: assert property ($rose(conv_start) |-> ##1 quiet_s)
        else $error("chain output moved during conversion");
    busy_irq_a: assert property (busy_start_s |-> ##1 quiet_s ##[30:50] chain_out)
        else $error("busy bit missing after conversion");
    idle_clk_a: assert property ($rose(conv_start) && !link_clk |-> ##1 (!link_clk) [*8])
        else $error("link clock moved in no-busy conversion");
    hold_start_a: assert property ($fell(link_clk) |-> conv_start)
        else $error("link clock fell with start line low");
    clk_half_a: assert property ($fell(link_clk) |-> ##1 (!link_clk) [*3])
        else $error("link clock low phase too short");
    shift_fall_a: assert property (since_r > 6'h2d && $changed(chain_out) |-> $fell(link_clk))
        else $error("chain output changed off a falling edge");
    oe_on_a: assert property ($rose(conv_start) |-> chain_out_oe ##40 chain_out_oe)
        else $error("chain output not driven in chained mode");
endmodule : adc_link_sva

/* File: verification/tb_top.sv */
// Testbench: host reading a chain of two converters.
// Assumes the host makes the link clock from the system clock.
`timescale 1ns/1ps
module tb_top
    import adc_pkg::*;
;
    localparam logic [15:0] SA_T [4] = '{16'h8001, 16'h7ffe, 16'hffff, 16'h0000};
    localparam logic [15:0] SB_T [4] = '{16'h3c5a, 16'hc3a5, 16'h0001, 16'hfffe};

    logic        sys_clk = 1'b0;
    logic        resetn, start, use_busy, rx_valid, done, active;
    logic        cdone_a, pw_a, daisy_a, daisy_b, bsel_a, bsel_b;
    logic [3:0]  dev_count;
    logic [15:0] samp_a, samp_b, rx_data;
    int          mismatches, checked, falls;

    adc_link_if if_h ();
    adc_link_if if_a ();
    adc_link_if if_b ();

    // System clock, 25 ns
    always #12.5 sys_clk = ~sys_clk;

    // Chain: host to first device, first to last, last back to host
    assign if_a.conv_start = if_h.conv_start;
    assign if_b.conv_start = if_h.conv_start;
    assign if_a.link_clk = if_h.link_clk;
    assign if_b.link_clk = if_h.link_clk;
    assign if_a.chain_in = if_h.chain_in;
    assign if_b.chain_in = if_a.chain_out;
    assign if_h.chain_out = if_b.chain_out;
    assign if_h.chain_out_oe = if_b.chain_out_oe;

    adc_host adc_host_i (.SYS_CLK(sys_clk), .RESETN(resetn), .LNK(if_h.host), .START(start),
        .USE_BUSY(use_busy), .DEV_COUNT(dev_count), .RX_DATA(rx_data), .RX_VALID(rx_valid),
        .DONE(done), .ACTIVE(active));
    adc_dev adc_dev_i (.SYS_CLK(sys_clk), .RESETN(resetn), .LNK(if_a.dev), .SAMPLE_IN(samp_a),
        .CONV_DONE(cdone_a), .POWERED(pw_a), .DAISY_MODE(daisy_a), .BUSY_SEL(bsel_a));
    adc_dev adc_dev_last_i (.SYS_CLK(sys_clk), .RESETN(resetn), .LNK(if_b.dev),
        .SAMPLE_IN(samp_b), .CONV_DONE(), .POWERED(), .DAISY_MODE(daisy_b), .BUSY_SEL(bsel_b));
    adc_link_sva adc_link_sva_i (.SYS_CLK(sys_clk), .RESETN(resetn),
        .conv_start(if_a.conv_start), .link_clk(if_a.link_clk), .chain_in(if_a.chain_in),
        .chain_out(if_a.chain_out), .chain_out_oe(if_a.chain_out_oe));

    // Falling link clock edges within a frame
    always @(negedge if_h.link_clk) begin
        if (if_h.conv_start)
            falls++;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic give_verdict;
        $display("mismatches %0d, checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    // One chained conversion and readout, then compare
    task automatic run(input logic busy, input logic [3:0] n, input logic [15:0] sa, sb);
        logic [15:0] got[$];
        int          pw, cd, dn;
        pw = 0;
        cd = 0;
        dn = 0;
        repeat (8) @(posedge sys_clk);
        chk(16'(pw_a), 16'h0000);
        chk(16'(if_h.chain_out), 16'h0000);
        falls = 0;
        samp_a <= sa;
        samp_b <= sb;
        use_busy <= busy;
        dev_count <= n;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        for (int i = 0; i < 2000 && dn == 0; i++) begin
            @(posedge sys_clk);
            if (i == 10) begin
                samp_a <= ~sa;
                samp_b <= ~sb;
            end
            #1;
            if (i == 20) begin
                chk(16'(daisy_a & daisy_b), 16'h0001);
                chk(16'({bsel_a, bsel_b}), 16'({busy, busy}));
                chk(16'(pw_a), 16'h0001);
                chk(16'(active), 16'h0001);
                chk(16'(if_h.chain_out_oe), 16'h0001);
            end
            pw += int'(pw_a === 1'b1);
            cd += int'(cdone_a === 1'b1);
            if (rx_valid === 1'b1)
                got.push_back(rx_data);
            dn = int'(done === 1'b1);
        end
        chk(16'(got.size()), 16'(n));
        for (int k = 0; k < got.size() && k < 2; k++)
            chk(got[k], k == 0 ? sb : sa);
        chk(16'(falls), 16'(16 * n + busy));
        chk(16'(pw >= CONV_CYCLES - 1 && pw <= CONV_CYCLES + 1), 16'h0001);
        chk(16'(cd), 16'h0001);
        chk(16'(pw_a), 16'h0000);
        chk(16'(active), 16'h0000);
    endtask : run

    // Main sequence: both modes, two devices and one, four reads
    initial begin
        resetn = 1'b0;
        start = 1'b0;
        use_busy = 1'b0;
        dev_count = 4'h1;
        samp_a = 16'h0000;
        samp_b = 16'h0000;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        for (int t = 0; t < 4; t++)
            run(1'(t % 2), 4'(t < 2 ? 2 : 1), SA_T[t], SB_T[t]);
        give_verdict();
    end

    // Watchdog against a hung run
    initial begin
        #(10000 * 25);
        mismatches++;
        give_verdict();
    end
endmodule : tb_top
